// >>> src/dpt_event_in.sv
/*
  Count input of timer 0: synchroniser, optional noise rejector, edge select.
  Assumes filter_tick_i pulses once per falling edge of the 2048 Hz tick.
*/
`timescale 1ns/1ns
module dpt_event_in (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  input wire logic filter_tick_i,
  input wire logic filter_en_i,
  input wire logic polarity_i,
  output logic count_o
);
  logic s1_reg;
  logic s2_reg;
  logic lvl_reg;
  logic prev_reg;
  logic [1:0] ticks_reg;

  // count pin idles high: reset to that level so release shows no false edge
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
    end
  end

  // with the filter on, a change is taken only if it still stands at the second filter tick seen after it
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_reg <= 1'b1;
      ticks_reg <= 2'h0;
    end else if (!filter_en_i) begin
      lvl_reg <= s2_reg;
      ticks_reg <= 2'h0;
    end else if (s2_reg == lvl_reg) begin
      ticks_reg <= 2'h0;
    end else if (filter_tick_i) begin
      if (ticks_reg + 2'h1 == dpt_pkg::FILTER_ACCEPT) begin
        lvl_reg <= s2_reg;
        ticks_reg <= 2'h0;
      end else begin
        ticks_reg <= ticks_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= lvl_reg;
    end
  end

  assign count_o = polarity_i ? (lvl_reg & ~prev_reg) : (prev_reg & ~lvl_reg);

  noise_accept_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    filter_en_i && $past(filter_en_i) && $changed(lvl_reg) |-> $past(filter_tick_i))
    else $error("filtered level changed off a filter tick");
  direct_follow_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !filter_en_i |=> lvl_reg == $past(s2_reg))
    else $error("unfiltered level does not follow input");
  edge_pick_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    count_o |-> lvl_reg == polarity_i)
    else $error("count on wrong edge");
endmodule : dpt_event_in

// >>> src/dpt_pkg.sv
/*
  Package of the dual 8-bit programmable timer: register offsets, field
  positions, reset values, divider masks and shared types.
  Assumes the top decodes word indices on Avalon-MM (byte address = 4 * index).
*/
package dpt_pkg;
  // ********************
  // register indices
  // ********************
  localparam logic [15:0] OFS_MODE = 16'hFFC0;
  localparam logic [15:0] OFS_CLKOUT = 16'hFFC1;
  localparam logic [15:0] OFS_SRC = 16'hFFC2;
  localparam logic [1:0][15:0] OFS_CTRL = {16'hFFC4, 16'hFFC3};
  localparam logic [1:0][15:0] OFS_RLD_L = {16'hFFC8, 16'hFFC6};
  localparam logic [1:0][15:0] OFS_RLD_H = {16'hFFC9, 16'hFFC7};
  localparam logic [1:0][15:0] OFS_CNT_L = {16'hFFCE, 16'hFFCC};
  localparam logic [1:0][15:0] OFS_CNT_H = {16'hFFCF, 16'hFFCD};
  localparam logic [1:0][15:0] OFS_CMP_L = {16'hFFD4, 16'hFFD2};
  localparam logic [1:0][15:0] OFS_CMP_H = {16'hFFD5, 16'hFFD3};
  localparam logic [15:0] OFS_PWM = 16'hFFD8;
  localparam logic [15:0] OFS_MATCH_MASK = 16'hFFE0;
  localparam logic [15:0] OFS_UF_MASK = 16'hFFE1;
  localparam logic [15:0] OFS_MATCH_PEND = 16'hFFF0;
  localparam logic [15:0] OFS_UF_PEND = 16'hFFF1;
  // ********************
  // fields and resets
  // ********************
  localparam int unsigned POS_CHSEL = 1;
  localparam int unsigned POS_OUTEN = 0;
  localparam int unsigned POS_RATIO = 2;
  localparam int unsigned POS_PRESET = 1;
  localparam int unsigned POS_RUN = 0;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ********************
  // timing
  // ********************
  localparam int unsigned LOW_OSC_HZ = 32768;
  localparam int unsigned FILTER_HZ = 2048;
  localparam int unsigned FILTER_DIV = LOW_OSC_HZ / FILTER_HZ;
  localparam logic [1:0] FILTER_ACCEPT = 2'h2;
  localparam logic [7:0] DIV1_MASK = 8'h00;
  localparam logic [7:0] DIV4_MASK = 8'h03;
  localparam logic [7:0] DIV32_MASK = 8'h1F;
  localparam logic [7:0] DIV256_MASK = 8'hFF;
  // ********************
  // types
  // ********************
  typedef struct packed {
    logic chain_wide_select;
    logic event_count_mode;
    logic noise_filter_enable;
    logic count_edge_polarity;
  } dpt_mode_cfg_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DONE = 2'b10} dpt_bus_state_t;
endpackage : dpt_pkg

// >>> src/dpt_prescaler.sv
/*
  Prescaler of one timer: divides source ticks by 1, 4, 32 or 256.
  Assumes src_tick_i is a one-cycle pulse per source falling edge.
*/
`timescale 1ns/1ns
module dpt_prescaler (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic src_tick_i,
  input wire logic [1:0] ratio_i,
  output logic tick_o
);
  logic [7:0] cnt_reg;
  logic [7:0] mask;

  always_comb begin
    case (ratio_i)
      2'h3: mask = dpt_pkg::DIV256_MASK;
      2'h2: mask = dpt_pkg::DIV32_MASK;
      2'h1: mask = dpt_pkg::DIV4_MASK;
      default: mask = dpt_pkg::DIV1_MASK;
    endcase
  end

  assign tick_o = src_tick_i && ((cnt_reg & mask) == mask);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= dpt_pkg::BYTE_RESET;
    end else if (src_tick_i) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  div_four_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    tick_o && ratio_i == 2'h1 |-> cnt_reg[1:0] == 2'h3)
    else $error("divide by four tick off phase");
endmodule : dpt_prescaler

// >>> src/dpt_timer_top.sv
/*
  Dual 8-bit programmable timer with 16-bit chaining, PWM and clock output,
  reached over an Avalon-MM slave with waitrequest (4-bit registers in bits 3:0).
  Assumes oscillator and count pins are asynchronous and sampled at 10 MHz.
*/
`timescale 1ns/1ns
module dpt_timer_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic low_speed_oscillator_i,
  input wire logic high_speed_oscillator_i,
  input wire logic event_count_input_pin_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic shared_output_pin_o,
  output logic timer_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // ********************
  // oscillator sampling
  // ********************
  logic [1:0] osc_s1_reg;
  logic [1:0] osc_s2_reg;
  logic [1:0] osc_s3_reg;
  logic [1:0] osc_fall;
  logic [3:0] fdiv_reg;
  logic filter_tick;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_s1_reg <= 2'h0;
      osc_s2_reg <= 2'h0;
      osc_s3_reg <= 2'h0;
    end else begin
      osc_s1_reg <= {high_speed_oscillator_i, low_speed_oscillator_i};
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end
  // timers count on the falling edge of their oscillator source, unless timer 0 counts pin edges in event mode
  assign osc_fall = osc_s3_reg & ~osc_s2_reg;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fdiv_reg <= 4'h0;
    end else if (osc_fall[0]) begin
      fdiv_reg <= fdiv_reg + 4'h1;
    end
  end
  assign filter_tick = osc_fall[0] && (fdiv_reg == 4'(dpt_pkg::FILTER_DIV - 1));

  // ********************
  // bus slave
  // ********************
  dpt_pkg::dpt_bus_state_t bus_state_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [15:0] idx;
  logic [3:0] wdat;
  logic wr_go;
  logic rd_cap;
  logic [3:0] rd_nib;

  assign idx = avs_address_i[17:2];
  assign wdat = avs_writedata_i[3:0];
  // writes land on the edge after the one that drops waitrequest, never earlier
  assign wr_go = avs_write_i && bus_state_reg == dpt_pkg::BUS_DONE && avs_byteenable_i[0];
  assign rd_cap = avs_read_i && bus_state_reg == dpt_pkg::BUS_IDLE;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_state_reg <= dpt_pkg::BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      case (bus_state_reg)
        dpt_pkg::BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_reg <= dpt_pkg::BUS_DONE;
            wait_reg <= 1'b0;
            rdata_reg <= avs_read_i ? {28'h000_0000, rd_nib} : 32'h0000_0000;
          end
        end
        default: begin
          bus_state_reg <= dpt_pkg::BUS_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end
  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o = rdata_reg;

  // ********************
  // control registers
  // ********************
  dpt_pkg::dpt_mode_cfg_t mode_reg;
  logic clock_out_channel_select_reg;
  logic clock_out_enable_reg;
  logic [1:0] source_select_reg;
  logic [1:0] pwm_select_reg;
  logic [1:0] match_mask_reg;
  logic [1:0] underflow_mask_reg;
  logic wide;

  assign wide = mode_reg.chain_wide_select;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg <= dpt_pkg::NIB_RESET;
      clock_out_channel_select_reg <= 1'b0;
      clock_out_enable_reg <= 1'b0;
      source_select_reg <= 2'h0;
      pwm_select_reg <= 2'h0;
      match_mask_reg <= 2'h0;
      underflow_mask_reg <= 2'h0;
    end else if (wr_go) begin
      case (idx)
        dpt_pkg::OFS_MODE: mode_reg <= wdat;
        dpt_pkg::OFS_CLKOUT: begin
          clock_out_channel_select_reg <= wdat[dpt_pkg::POS_CHSEL];
          clock_out_enable_reg <= wdat[dpt_pkg::POS_OUTEN];
        end
        dpt_pkg::OFS_SRC: source_select_reg <= wdat[1:0];
        dpt_pkg::OFS_PWM: pwm_select_reg <= wdat[1:0];
        dpt_pkg::OFS_MATCH_MASK: match_mask_reg <= wdat[1:0];
        dpt_pkg::OFS_UF_MASK: underflow_mask_reg <= wdat[1:0];
        default: ;
      endcase
    end
  end

  // ********************
  // timer datapath
  // ********************
  logic [1:0] run_req_reg;
  logic [1:0] active_reg;
  logic [1:0] wave_reg;
  logic [1:0] underflow_flag_reg;
  logic [1:0] match_flag_reg;
  logic [1:0][1:0] ratio_reg;
  logic [1:0][7:0] reload_reg;
  logic [1:0][7:0] compare_reg;
  logic [1:0][7:0] count_reg;
  logic [1:0][7:0] count_next;
  logic [1:0][3:0] hold_reg;
  logic [1:0] src_tick;
  logic [1:0] presc_tick;
  logic [1:0] tick;
  logic [1:0] step;
  logic [1:0] zero;
  logic [1:0] uf;
  logic [1:0] load;
  logic [1:0] preset;
  logic [1:0] match;
  logic [1:0] pwm_eff;
  logic ev_pulse;

  dpt_event_in u_event_in (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pin_i(event_count_input_pin_i),
    .filter_tick_i(filter_tick),
    .filter_en_i(mode_reg.noise_filter_enable),
    .polarity_i(mode_reg.count_edge_polarity),
    .count_o(ev_pulse)
  );

  always_comb begin
    tick[0] = mode_reg.event_count_mode ? ev_pulse : presc_tick[0];
    tick[1] = wide ? tick[0] : presc_tick[1];
    zero[0] = count_reg[0] == dpt_pkg::BYTE_RESET;
    zero[1] = count_reg[1] == dpt_pkg::BYTE_RESET;
    preset[0] = wr_go && idx == dpt_pkg::OFS_CTRL[0] && wdat[dpt_pkg::POS_PRESET];
    preset[1] = wide ? preset[0]
      : (wr_go && idx == dpt_pkg::OFS_CTRL[1] && wdat[dpt_pkg::POS_PRESET]);
    pwm_eff = {pwm_select_reg[1] & ~wide, pwm_select_reg[0]};
    if (wide) begin
      step[0] = tick[0] & active_reg[0];
      step[1] = step[0] & zero[0];
      uf = {step[0] & zero[0] & zero[1], 1'b0};
      load = {2{uf[1] | preset[0]}};
    end else begin
      step = tick & active_reg;
      uf = step & zero;
      load = uf | preset;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_timer
    assign src_tick[i] = source_select_reg[i] ? osc_fall[1] : osc_fall[0];

    dpt_prescaler u_prescaler (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .src_tick_i(src_tick[i]),
      .ratio_i(ratio_reg[i]),
      .tick_o(presc_tick[i])
    );

    always_comb begin
      if (load[i]) begin
        count_next[i] = reload_reg[i];
      end else if (step[i]) begin
        count_next[i] = count_reg[i] - 8'h01;
      end else begin
        count_next[i] = count_reg[i];
      end
    end
    assign match[i] = step[i] && pwm_eff[i] && count_next[i] == compare_reg[i];

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        count_reg[i] <= dpt_pkg::BYTE_RESET;
      end else begin
        count_reg[i] <= count_next[i];
      end
    end

    // run changes only at the timer's own input clock edge
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        active_reg[i] <= 1'b0;
      end else if (tick[i]) begin
        active_reg[i] <= run_req_reg[i];
      end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        run_req_reg[i] <= 1'b0;
        ratio_reg[i] <= 2'h0;
      end else if (wr_go && idx == dpt_pkg::OFS_CTRL[i]) begin
        run_req_reg[i] <= wdat[dpt_pkg::POS_RUN];
        ratio_reg[i] <= wdat[dpt_pkg::POS_RATIO +: 2];
      end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        reload_reg[i] <= dpt_pkg::BYTE_RESET;
        compare_reg[i] <= dpt_pkg::BYTE_RESET;
      end else if (wr_go) begin
        if (idx == dpt_pkg::OFS_RLD_L[i]) reload_reg[i][3:0] <= wdat;
        if (idx == dpt_pkg::OFS_RLD_H[i]) reload_reg[i][7:4] <= wdat;
        if (idx == dpt_pkg::OFS_CMP_L[i]) compare_reg[i][3:0] <= wdat;
        if (idx == dpt_pkg::OFS_CMP_H[i]) compare_reg[i][7:4] <= wdat;
      end
    end

    // high nibble frozen by the low read so the pair is coherent
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        hold_reg[i] <= dpt_pkg::NIB_RESET;
      end else if (rd_cap && idx == dpt_pkg::OFS_CNT_L[i]) begin
        hold_reg[i] <= count_reg[i][7:4];
      end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        wave_reg[i] <= 1'b0;
      end else if (uf[i]) begin
        wave_reg[i] <= pwm_eff[i] ? 1'b1 : ~wave_reg[i];
      end else if (match[i]) begin
        wave_reg[i] <= 1'b0;
      end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        underflow_flag_reg[i] <= 1'b0;
        match_flag_reg[i] <= 1'b0;
      end else begin
        underflow_flag_reg[i] <= uf[i] | (underflow_flag_reg[i]
          & ~(wr_go && idx == dpt_pkg::OFS_UF_PEND && wdat[i]));
        match_flag_reg[i] <= match[i] | (match_flag_reg[i]
          & ~(wr_go && idx == dpt_pkg::OFS_MATCH_PEND && wdat[i]));
      end
    end
  end

  // ********************
  // read mux and outputs
  // ********************
  always_comb begin
    case (idx)
      dpt_pkg::OFS_MODE: rd_nib = mode_reg;
      dpt_pkg::OFS_CLKOUT: rd_nib = {2'h0, clock_out_channel_select_reg, clock_out_enable_reg};
      dpt_pkg::OFS_SRC: rd_nib = {2'h0, source_select_reg};
      dpt_pkg::OFS_CTRL[0]: rd_nib = {ratio_reg[0], 1'b0, run_req_reg[0] | active_reg[0]};
      dpt_pkg::OFS_CTRL[1]: rd_nib = {ratio_reg[1], 1'b0, run_req_reg[1] | active_reg[1]};
      dpt_pkg::OFS_RLD_L[0]: rd_nib = reload_reg[0][3:0];
      dpt_pkg::OFS_RLD_H[0]: rd_nib = reload_reg[0][7:4];
      dpt_pkg::OFS_RLD_L[1]: rd_nib = reload_reg[1][3:0];
      dpt_pkg::OFS_RLD_H[1]: rd_nib = reload_reg[1][7:4];
      dpt_pkg::OFS_CNT_L[0]: rd_nib = count_reg[0][3:0];
      dpt_pkg::OFS_CNT_H[0]: rd_nib = hold_reg[0];
      dpt_pkg::OFS_CNT_L[1]: rd_nib = count_reg[1][3:0];
      dpt_pkg::OFS_CNT_H[1]: rd_nib = hold_reg[1];
      dpt_pkg::OFS_CMP_L[0]: rd_nib = compare_reg[0][3:0];
      dpt_pkg::OFS_CMP_H[0]: rd_nib = compare_reg[0][7:4];
      dpt_pkg::OFS_CMP_L[1]: rd_nib = compare_reg[1][3:0];
      dpt_pkg::OFS_CMP_H[1]: rd_nib = compare_reg[1][7:4];
      dpt_pkg::OFS_PWM: rd_nib = {2'h0, pwm_select_reg};
      dpt_pkg::OFS_MATCH_MASK: rd_nib = {2'h0, match_mask_reg};
      dpt_pkg::OFS_UF_MASK: rd_nib = {2'h0, underflow_mask_reg};
      dpt_pkg::OFS_MATCH_PEND: rd_nib = {2'h0, match_flag_reg};
      dpt_pkg::OFS_UF_PEND: rd_nib = {2'h0, underflow_flag_reg};
      default: rd_nib = dpt_pkg::NIB_RESET;
    endcase
  end

  // pin is re-timed here, so the enable toggle leaves no half-cycle glitch
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shared_output_pin_o <= 1'b1;
      timer_irq_o <= 1'b0;
    end else begin
      shared_output_pin_o <= clock_out_enable_reg
        ? wave_reg[wide | clock_out_channel_select_reg] : 1'b1;
      timer_irq_o <= |((underflow_flag_reg & underflow_mask_reg)
        | (match_flag_reg & match_mask_reg));
    end
  end

  // ********************
  // checks
  // ********************
  sequence bus_req_s;
    (avs_read_i || avs_write_i) && bus_state_reg == dpt_pkg::BUS_IDLE;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not one wait cycle");
  preset_load_a: assert property (preset[0] && !wide |=> count_reg[0] == $past(reload_reg[0]))
    else $error("preset did not load reload value");
  stop_hold_a: assert property (!active_reg[0] && !wide && !load[0] |=> $stable(count_reg[0]))
    else $error("stopped counter moved");
  run_edge_a: assert property ($changed(active_reg[0]) |-> $past(tick[0]))
    else $error("run state changed off input clock");
  run_read_a: assert property (active_reg[0] |-> (rd_nib[0] || idx != dpt_pkg::OFS_CTRL[0]))
    else $error("run reads 0 while running");
  uf_flag_a: assert property (uf[0] |=> underflow_flag_reg[0])
    else $error("underflow flag not set");
  match_flag_a: assert property (match[1] && !uf[1] |=> match_flag_reg[1] && !wave_reg[1])
    else $error("compare match lost");
  flag_clear_a: assert property (wr_go && idx == dpt_pkg::OFS_UF_PEND && wdat[0]
    && !uf[0] |=> !underflow_flag_reg[0])
    else $error("flag not cleared by write one");
  pin_idle_a: assert property (!clock_out_enable_reg |=> shared_output_pin_o)
    else $error("pin not high while output off");
  wide_route_a: assert property (wide && clock_out_enable_reg
    |=> shared_output_pin_o == $past(wave_reg[1]))
    else $error("chained mode did not route timer 1");
  wide_high_a: assert property (wide && step[0] && !zero[0] && !preset[0]
    |=> $stable(count_reg[1]))
    else $error("high byte stepped without low underflow");
  hold_a: assert property (rd_cap && idx == dpt_pkg::OFS_CNT_L[0]
    |=> hold_reg[0] == $past(count_reg[0][7:4]))
    else $error("high nibble not held");
endmodule : dpt_timer_top

// >>> tb/dpt_event_src.sv
/*
  Pulse source for the timer 0 count pin: idle high, one low pulse per request.
  Assumes the bench raises fire_i for one cycle while the source is idle.
*/
`timescale 1ns/1ns
module dpt_event_src (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic fire_i,
  input wire logic [11:0] len_i,
  output logic pin_o
);
  logic [11:0] left_reg;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_reg <= 12'h000;
    end else if (fire_i && left_reg == 12'h000) begin
      left_reg <= len_i;
    end else if (left_reg != 12'h000) begin
      left_reg <= left_reg - 12'h001;
    end
  end
  // pin driven at all times, so no stale level is ever left floating
  assign pin_o = (left_reg == 12'h000);
endmodule : dpt_event_src

// >>> tb/tb.sv
/*
  Testbench of the dual timer: registers, underflow flags, clock out, event count.
  Assumes the one-wait-cycle Avalon slave of the top module.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  localparam logic [15:0] CT0 = dpt_pkg::OFS_CTRL[0];
  localparam logic [15:0] CL0 = dpt_pkg::OFS_CNT_L[0];
  localparam logic [15:0] UFP = dpt_pkg::OFS_UF_PEND;
  logic clk = 1'b0, nrst = 1'b0, lo = 1'b0, hi = 1'b0, rd = 1'b0, wr = 1'b0, fire = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdata;
  logic [11:0] len = 12'h008;
  logic [7:0] div = 8'h00, a, b;
  logic [3:0] q;
  logic waitrq, pin, irq, evp;
  int mismatches = 0;
  int checks = 0;
  always #50 clk = ~clk;
  // slow source: 32 cycles a period; fast source: 8 cycles
  always @(posedge clk) begin
    div <= div + 8'h01;
    if (div[1:0] == 2'h3) hi <= ~hi;
    if (div[3:0] == 4'hF) lo <= ~lo;
  end
  dpt_timer_top dut (.core_clk_i(clk), .nrst_i(nrst), .low_speed_oscillator_i(lo),
    .high_speed_oscillator_i(hi), .event_count_input_pin_i(evp), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitrq), .shared_output_pin_o(pin),
    .timer_irq_o(irq));
  dpt_event_src src (.core_clk_i(clk), .nrst_i(nrst), .fire_i(fire), .len_i(len),
    .pin_o(evp));
  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic bus(input logic w, input logic [15:0] i, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= {28'h0000000, d};
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (waitrq !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 20) begin mismatches++; final_report(); end
    end
    q = rdata[3:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [15:0] i, input logic [3:0] e, input string n);
    bus(1'b0, i, 4'h0);
    `CHK(n, e, q)
  endtask : rchk
  task automatic cnt0;
    bus(1'b0, CL0, 4'h0);
    a[3:0] = q;
    bus(1'b0, dpt_pkg::OFS_CNT_H[0], 4'h0);
    a[7:4] = q;
  endtask : cnt0
  task automatic pulse(input logic [11:0] l);
    len <= l;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (l + 40) @(posedge clk);
  endtask : pulse
  task automatic t_regs;
    rchk(dpt_pkg::OFS_MODE, 4'h0, "mode");
    rchk(dpt_pkg::OFS_SRC, 4'h0, "source");
    rchk(CT0, 4'h0, "ctrl0");
    rchk(CL0, 4'h0, "count");
    rchk(dpt_pkg::OFS_CMP_L[0], 4'h0, "compare");
    rchk(dpt_pkg::OFS_UF_MASK, 4'h0, "mask");
    rchk(UFP, 4'h0, "flags");
    bus(1'b1, 16'hFFC5, 4'hF);
    rchk(16'hFFC5, 4'h0, "unmapped");
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h9);
    rchk(dpt_pkg::OFS_MODE, 4'h9, "mode rw");
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_uf;
    int bad, chg;
    bad = 0;
    chg = 0;
    bus(1'b1, dpt_pkg::OFS_SRC, 4'h1);
    bus(1'b1, dpt_pkg::OFS_RLD_L[0], 4'h5);
    bus(1'b1, CT0, 4'h3);
    rchk(CT0, 4'h1, "preset reads 0");
    repeat (100) begin @(posedge clk); if (pin !== 1'b1) bad++; end
    `CHK("pin idle", 0, bad)
    q = 4'h0;
    while (q[0] !== 1'b1 && chg < 100) begin bus(1'b0, UFP, 4'h0); chg++; end
    `CHK("uf flag", 1'b1, q[0])
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, dpt_pkg::OFS_UF_MASK, 4'h1);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, dpt_pkg::OFS_CLKOUT, 4'h1);
    chg = 0;
    b = {7'h00, pin};
    repeat (200) begin @(posedge clk); if (pin !== b[0]) chg++; b[0] = pin; end
    `CHK("pin toggles", 1'b1, (chg > 1))
    bus(1'b1, dpt_pkg::OFS_CLKOUT, 4'h3);
    bad = 0;
    repeat (2) @(posedge clk);
    repeat (100) begin @(posedge clk); if (pin !== 1'b0) bad++; end
    `CHK("timer1 routed", 0, bad)
    cnt0();
    `CHK("count range", 1'b1, (a <= 8'h05))
    bus(1'b1, CT0, 4'h0);
    repeat (40) @(posedge clk);
    rchk(CT0, 4'h0, "stopped");
    cnt0();
    b = a;
    repeat (100) @(posedge clk);
    bus(1'b1, CL0, 4'hF);
    cnt0();
    `CHK("held count", b, a)
    bus(1'b1, UFP, 4'h1);
    rchk(UFP, 4'h0, "flag clear");
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    bus(1'b1, dpt_pkg::OFS_CLKOUT, 4'h0);
    $display("underflow done");
  endtask : t_uf
  task automatic t_ev;
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h4);
    bus(1'b1, dpt_pkg::OFS_RLD_L[0], 4'h0);
    bus(1'b1, dpt_pkg::OFS_RLD_H[0], 4'h1);
    bus(1'b1, CT0, 4'h3);
    repeat (2) pulse(12'h008);
    cnt0();
    b = a;
    repeat (3) pulse(12'h008);
    cnt0();
    `CHK("event count", b - 8'h03, a)
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h6);
    b = a;
    pulse(12'h008);
    repeat (1200) @(posedge clk);
    cnt0();
    `CHK("short rejected", b, a)
    pulse(12'h640);
    repeat (1200) @(posedge clk);
    cnt0();
    `CHK("long counted", b - 8'h01, a)
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h5);
    b = a;
    pulse(12'h008);
    cnt0();
    `CHK("rising edge", b - 8'h01, a)
    $display("event done");
  endtask : t_ev
  task automatic t_pwm;
    int hcnt;
    hcnt = 0;
    bus(1'b1, dpt_pkg::OFS_SRC, 4'h2);
    bus(1'b1, dpt_pkg::OFS_RLD_L[1], 4'h7);
    bus(1'b1, dpt_pkg::OFS_CMP_L[1], 4'h2);
    bus(1'b1, dpt_pkg::OFS_PWM, 4'h2);
    bus(1'b1, dpt_pkg::OFS_CLKOUT, 4'h3);
    bus(1'b1, dpt_pkg::OFS_CTRL[1], 4'h7);
    repeat (600) @(posedge clk);
    // 8 ticks of 32 cycles a period, high for 5 ticks, 4 periods
    repeat (1024) begin @(posedge clk); if (pin === 1'b1) hcnt++; end
    `CHK("pwm duty", 32'h0000_0280, hcnt)
    rchk(dpt_pkg::OFS_MATCH_PEND, 4'h2, "match flag");
    bus(1'b1, dpt_pkg::OFS_CTRL[1], 4'h0);
    repeat (300) @(posedge clk);
    bus(1'b1, dpt_pkg::OFS_MATCH_PEND, 4'h2);
    rchk(dpt_pkg::OFS_MATCH_PEND, 4'h0, "match clear");
    bus(1'b1, dpt_pkg::OFS_CLKOUT, 4'h0);
    bus(1'b1, dpt_pkg::OFS_PWM, 4'h0);
    $display("pwm done");
  endtask : t_pwm
  task automatic t_wide;
    bus(1'b1, dpt_pkg::OFS_SRC, 4'h1);
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h8);
    bus(1'b1, dpt_pkg::OFS_RLD_L[0], 4'h3);
    bus(1'b1, dpt_pkg::OFS_RLD_H[0], 4'h0);
    bus(1'b1, dpt_pkg::OFS_RLD_L[1], 4'h1);
    bus(1'b1, CT0, 4'h3);
    repeat (100) @(posedge clk);
    bus(1'b1, CT0, 4'h0);
    repeat (40) @(posedge clk);
    cnt0();
    `CHK("wide low wrapped", 1'b1, (a > 8'hF0))
    rchk(dpt_pkg::OFS_CNT_L[1], 4'h0, "wide high low");
    rchk(dpt_pkg::OFS_CNT_H[1], 4'h0, "wide high high");
    bus(1'b1, dpt_pkg::OFS_MODE, 4'h0);
    $display("wide done");
  endtask : t_wide
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("pin reset", 1'b1, pin)
    t_regs();
    t_uf();
    t_ev();
    t_pwm();
    t_wide();
    final_report();
  end
endmodule : tb
